// [src/atnrst_top.sv]
// Overview of operation
// (R1) Attention input high drives the module reset line low.
// (R2) Attention low or floating holds the module reset line high; while SRST is high the code drives it low (RST_LINE_RESET).
// (R3) Host pulses attention low, high, low to reset before downloading.
// (R4) Attention held high keeps the module in reset; no execution.
// (R5) Host reusing the port should drive the handshake low after opening.
// (R6) After a good download, execution starts at the first instruction.
// (R7) On power-up, execution starts at the first stored instruction.
// (R8) Download erases only aligned 16-byte chunks, then rewrites needed bytes.
// (R9) Erase happens inside the download; no separate erase command.
// (R10) Attention is synchronised; glitches under two cycles are ignored.
module atnrst_top #(
  parameter int unsigned ADDR_W = atnrst_pkg::ADDR_W
) (
  // Clock and reset.
  input  wire logic              SYS_CLK,
  input  wire logic              SRST,
  // Attention and module reset.
  input  wire logic              ATTENTION_INPUT,
  output logic                   MODULE_RESET_LINE,
  // Download byte stream.
  input  wire logic              DL_START,
  input  wire logic              DL_VALID,
  input  wire logic [ADDR_W-1:0] DL_ADDR,
  input  wire logic [7:0]        DL_DATA,
  input  wire logic              DL_DONE,
  output logic                   DL_READY,
  // Program memory port.
  output logic                   MEM_WE,
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic [7:0]             MEM_WDATA,
  // Interpreter control.
  output logic                   RUN,
  output logic                   PC_LOAD,
  output logic [ADDR_W-1:0]      PC_START
);

  localparam int unsigned CW = atnrst_pkg::CHUNK_W;

  typedef struct packed {
    atnrst_pkg::atnrst_state_t state;
    logic                      rst_line;
    logic                      boot;
    logic [(1<<(ADDR_W-CW))-1:0] erased;
    logic [ADDR_W-1:0]         cur_addr;
    logic [7:0]                cur_data;
    logic [CW-1:0]             ecnt;
    logic                      ready;
    logic                      we;
    logic [ADDR_W-1:0]         maddr;
    logic [7:0]                mdata;
    logic                      run;
    logic                      pc_load;
  } atnrst_st_t;

  atnrst_st_t st_reg;
  atnrst_st_t st_next;
  logic       atn_sync;

  atnrst_sync_if sif ();
  assign sif.raw = ATTENTION_INPUT;
  assign atn_sync = sif.synced;

  atnrst_sync u_sync (
    .clk  (SYS_CLK),
    .srst (SRST),
    .sif  (sif)
  );

  always_comb begin
    st_next = st_reg;
    st_next.we = 1'b0;
    st_next.pc_load = 1'b0;
    st_next.rst_line = !atn_sync; // R1 R2
    unique case (st_reg.state)
      atnrst_pkg::ATNRST_IDLE: begin
        // Power-up: begin at the first stored instruction.
        if (st_reg.boot) begin
          st_next.boot = 1'b0;
          st_next.pc_load = 1'b1; // R7
          st_next.run = 1'b1;
          st_next.state = atnrst_pkg::ATNRST_RUN;
        end
      end
      atnrst_pkg::ATNRST_RUN: begin
        if (DL_START) begin
          st_next.run = 1'b0;
          st_next.erased = '0;
          st_next.ready = 1'b1;
          st_next.state = atnrst_pkg::ATNRST_WRITE;
        end
      end
      atnrst_pkg::ATNRST_WRITE: begin
        if (!st_reg.ready) begin
          // Write the held byte back once its chunk has been erased.
          st_next.we = 1'b1;
          st_next.maddr = st_reg.cur_addr; // R8
          st_next.mdata = st_reg.cur_data;
          st_next.ready = 1'b1;
        end else if (DL_VALID) begin
          st_next.cur_addr = DL_ADDR;
          st_next.cur_data = DL_DATA;
          st_next.ready = 1'b0;
          if (!st_reg.erased[DL_ADDR[ADDR_W-1:CW]]) begin
            // Erase the enclosing aligned chunk first.
            st_next.ecnt = '0;
            st_next.erased[DL_ADDR[ADDR_W-1:CW]] = 1'b1; // R8 R9
            st_next.state = atnrst_pkg::ATNRST_ERASE;
          end else begin
            st_next.we = 1'b1;
            st_next.maddr = DL_ADDR;
            st_next.mdata = DL_DATA;
            st_next.ready = 1'b1;
          end
        end
        // A finish strobe is honoured whenever no byte is taken with it.
        if (DL_DONE && !(DL_VALID && st_reg.ready)) begin
          st_next.ready = 1'b0;
          st_next.pc_load = 1'b1; // R6
          st_next.run = 1'b1;
          st_next.state = atnrst_pkg::ATNRST_RUN;
        end
      end
      atnrst_pkg::ATNRST_ERASE: begin
        st_next.we = 1'b1;
        st_next.maddr = {st_reg.cur_addr[ADDR_W-1:CW], st_reg.ecnt}; // R8
        st_next.mdata = atnrst_pkg::ERASED_BYTE;
        st_next.ecnt = st_reg.ecnt + 1'b1;
        if (&st_reg.ecnt) begin
          st_next.state = atnrst_pkg::ATNRST_WRITE;
        end
      end
      default: begin
        st_next.state = atnrst_pkg::ATNRST_IDLE;
      end
    endcase
    // Attention high holds everything in reset.
    if (SRST || atn_sync) begin // R4
      st_next = '0;
      st_next.state = atnrst_pkg::ATNRST_IDLE;
      st_next.rst_line = SRST ? atnrst_pkg::RST_LINE_RESET : !atn_sync; // R1
      st_next.boot = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    st_reg <= st_next;
  end

  assign MODULE_RESET_LINE = st_reg.rst_line;
  assign DL_READY = st_reg.ready;
  assign MEM_WE = st_reg.we;
  assign MEM_ADDR = st_reg.maddr;
  assign MEM_WDATA = st_reg.mdata;
  assign RUN = st_reg.run;
  assign PC_LOAD = st_reg.pc_load;
  assign PC_START = atnrst_pkg::START_ADDR;

  a_rst_follows_atn: assert property ( // R1
    @(posedge SYS_CLK) disable iff (SRST)
    atn_sync |=> !MODULE_RESET_LINE)
    else $error("Reset line not low while attention high.");

  a_rst_released: assert property ( // R2
    @(posedge SYS_CLK) disable iff (SRST)
    !atn_sync |=> MODULE_RESET_LINE)
    else $error("Reset line not high while attention low.");

  a_no_run_in_rst: assert property ( // R4
    @(posedge SYS_CLK) disable iff (SRST)
    atn_sync |=> !RUN && !MEM_WE)
    else $error("Activity while attention is high.");

  a_dl_starts: assert property ( // R9
    @(posedge SYS_CLK) disable iff (SRST)
    st_reg.state == atnrst_pkg::ATNRST_RUN && DL_START && !atn_sync
    |=> !RUN && DL_READY && st_reg.erased == '0)
    else $error("Download did not open at once.");

  a_dl_done_run: assert property ( // R6
    @(posedge SYS_CLK) disable iff (SRST)
    st_reg.state == atnrst_pkg::ATNRST_WRITE && DL_DONE && !atn_sync
    && !(DL_VALID && DL_READY) |=> PC_LOAD && RUN)
    else $error("Program not started after download.");

  a_pc_load_once: assert property ( // R6
    @(posedge SYS_CLK) disable iff (SRST)
    PC_LOAD |=> !PC_LOAD)
    else $error("Start address loaded twice in a row.");

  a_boot_start: assert property ( // R7
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(atn_sync) |-> ##[1:3] PC_LOAD)
    else $error("No start after reset release.");

  a_start_addr: assert property ( // R7
    @(posedge SYS_CLK) disable iff (SRST)
    PC_LOAD |-> PC_START == atnrst_pkg::START_ADDR && RUN)
    else $error("Start address is not the first instruction.");

  a_erase_chunk: assert property ( // R8
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(st_reg.state == atnrst_pkg::ATNRST_ERASE) && !atn_sync
    |=> MEM_WE && MEM_ADDR[CW-1:0] == '0
    && MEM_WDATA == atnrst_pkg::ERASED_BYTE)
    else $error("Erase does not begin at chunk start.");

  a_erase_len: assert property ( // R8
    @(posedge SYS_CLK) disable iff (SRST || atn_sync)
    $rose(st_reg.state == atnrst_pkg::ATNRST_ERASE)
    |-> st_reg.ecnt == '0
    ##15 (st_reg.state == atnrst_pkg::ATNRST_ERASE && &st_reg.ecnt)
    ##1 st_reg.state == atnrst_pkg::ATNRST_WRITE)
    else $error("Erase length is not one chunk.");

  a_erase_busy: assert property ( // R9
    @(posedge SYS_CLK) disable iff (SRST)
    st_reg.state == atnrst_pkg::ATNRST_ERASE |-> !DL_READY)
    else $error("Byte slot offered during an erase.");

  a_write_back: assert property ( // R8
    @(posedge SYS_CLK) disable iff (SRST)
    $fell(st_reg.state == atnrst_pkg::ATNRST_ERASE) && !atn_sync
    && st_reg.state == atnrst_pkg::ATNRST_WRITE && !DL_DONE
    |=> MEM_WE && MEM_ADDR == $past(st_reg.cur_addr)
    && MEM_WDATA == $past(st_reg.cur_data) && DL_READY)
    else $error("Held byte not written after its erase.");

  a_write_direct: assert property ( // R8
    @(posedge SYS_CLK) disable iff (SRST)
    st_reg.state == atnrst_pkg::ATNRST_WRITE && DL_READY && DL_VALID
    && st_reg.erased[DL_ADDR[ADDR_W-1:CW]] && !atn_sync
    |=> MEM_WE && MEM_ADDR == $past(DL_ADDR)
    && MEM_WDATA == $past(DL_DATA) && DL_READY)
    else $error("Byte in an erased chunk not written at once.");

  c_boot: cover property (@(posedge SYS_CLK) $fell(atn_sync) ##[1:4] PC_LOAD);
  c_erase: cover property (@(posedge SYS_CLK)
    st_reg.state == atnrst_pkg::ATNRST_ERASE);
  c_dl_done: cover property (@(posedge SYS_CLK)
    st_reg.state == atnrst_pkg::ATNRST_WRITE && DL_DONE);
  c_abort: cover property (@(posedge SYS_CLK)
    st_reg.state == atnrst_pkg::ATNRST_ERASE && atn_sync);

endmodule

// [src/atnrst_pkg.sv]
package atnrst_pkg;

  // Program memory geometry.
  localparam int unsigned MEM_BYTES   = 2048;
  localparam int unsigned CHUNK_BYTES = 16;
  localparam int unsigned ADDR_W      = 11;
  localparam int unsigned CHUNK_W     = 4;

  // Value written into every byte of an erased chunk.
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Address of the first executable instruction.
  localparam logic [ADDR_W-1:0] START_ADDR = 11'h000;

  // Reset values of the reset line output and the synchroniser stages.
  localparam logic RST_LINE_RESET = 1'b0;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  // Download sequencer states.
  typedef enum logic [3:0] {
    ATNRST_IDLE  = 4'h1,
    ATNRST_ERASE = 4'h2,
    ATNRST_WRITE = 4'h4,
    ATNRST_RUN   = 4'h8
  } atnrst_state_t;

endpackage

// [src/atnrst_sync_if.sv]
interface atnrst_sync_if;
  logic raw;
  logic synced;
  modport src (input synced, output raw);
  modport snk (input raw, output synced);
endinterface

// [src/atnrst_sync.sv]
module atnrst_sync (
  // Clock and reset.
  input  wire logic    clk,
  input  wire logic    srst,
  // Signal path.
  atnrst_sync_if.snk   sif
);

  typedef struct packed {
    logic [1:0] stage;
    logic       hold;
    logic       filt;
  } atnrst_sync_st_t;

  atnrst_sync_st_t st_reg;
  atnrst_sync_st_t st_next;

  // The first stage is read only by the second one.
  always_comb begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[0], sif.raw}; // R10
    st_next.hold = st_reg.stage[1];
    // A level reaches the output only after two equal samples in a row.
    if (st_reg.stage[1] == st_reg.hold) begin
      st_next.filt = st_reg.stage[1]; // R10
    end
    if (srst) begin
      st_next = '0;
      st_next.stage = atnrst_pkg::SYNC_RESET;
    end
  end

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end

  assign sif.synced = st_reg.filt;

  a_sync_delay: assert property (@(posedge clk) disable iff (srst) // R10
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3) && !$past(srst, 4)
    && $past(sif.raw, 3) == $past(sif.raw, 4)
    |-> sif.synced == $past(sif.raw, 3))
    else $error("Synchroniser delay is not three cycles.");

  a_glitch_held: assert property (@(posedge clk) disable iff (srst) // R10
    !$past(srst) && !$past(srst, 2) && !$past(srst, 3) && !$past(srst, 4)
    && $past(sif.raw, 3) != $past(sif.raw, 4)
    |-> $stable(sif.synced))
    else $error("Short attention pulse reached the output.");

endmodule

// [tb/atnrst_host.sv]
module atnrst_host (
  // Clock.
  input  wire logic        clk,
  // Toward the device.
  output logic             attn,
  output logic             start,
  output logic             valid,
  output logic [10:0]      addr,
  output logic [7:0]       data,
  output logic             done,
  // From the device.
  input  wire logic        ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // The handshake line is driven low at once so the module is not held.
  initial begin
    attn = 1'h0;
    start = 1'h0;
    valid = 1'h0;
    done = 1'h0;
    addr = 11'h000;
    data = 8'h00;
  end
  task automatic level(input logic v);
    @(posedge clk);
    attn <= v;
  endtask
  task automatic reset_seq();
    level(1'h0);
    level(1'h1);
    repeat (8) @(posedge clk);
    level(1'h0);
  endtask
  // A zero selects the start strobe, anything else the finish strobe.
  task automatic pulse(input int sel);
    @(posedge clk);
    if (sel == 0) start <= 1'h1;
    else done <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    done <= 1'h0;
  endtask
  // Released lines show the inverse so stale values cannot pass.
  task automatic send(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    valid <= 1'h1;
    addr <= a;
    data <= d;
    do @(posedge clk); while (ready !== 1'h1);
    valid <= 1'h0;
    addr <= ~a;
    data <= ~d;
  endtask
endmodule

// [tb/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, srst, attn, start, valid, done, ready;
  logic        rst_line, mem_we, run, pc_load;
  logic [10:0] addr, mem_addr, pc_start;
  logic [7:0]  data, mem_wdata;
  logic [18:0] wq[$];
  int          failures, tests_run, loads;

  atnrst_top dut (
    .SYS_CLK(sys_clk), .SRST(srst), .ATTENTION_INPUT(attn),
    .MODULE_RESET_LINE(rst_line), .DL_START(start), .DL_VALID(valid),
    .DL_ADDR(addr), .DL_DATA(data), .DL_DONE(done), .DL_READY(ready),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .RUN(run), .PC_LOAD(pc_load), .PC_START(pc_start)
  );
  atnrst_host host (
    .clk(sys_clk), .attn(attn), .start(start), .valid(valid),
    .addr(addr), .data(data), .done(done), .ready(ready)
  );

  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string n, input logic [18:0] e,
                     input logic [18:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Memory writes and start-address loads are logged as they happen.
  always @(posedge sys_clk) begin
    if (mem_we === 1'h1) wq.push_back({mem_addr, mem_wdata});
    if (pc_load === 1'h1) begin
      loads++;
      chk("pc_start", 19'h0, pc_start);
    end
  end

  task automatic wait_run();
    int i;
    for (i = 0; i < 12 && run !== 1'h1; i++) @(negedge sys_clk);
    // One more edge lets the logger count the load launched with RUN.
    @(negedge sys_clk);
  endtask

  task automatic t_power();
    wait_run();
    chk("run", 19'h1, run);
    chk("rst_line", 19'h1, rst_line);
    chk("loads", 19'h1, 19'(loads));
    $display("test power done");
  endtask

  task automatic t_attn();
    host.level(1'h1);
    host.level(1'h0);
    repeat (8) @(negedge sys_clk);
    chk("rst_line", 19'h1, rst_line);
    chk("loads", 19'h1, 19'(loads));
    host.level(1'h1);
    repeat (2) @(negedge sys_clk);
    chk("rst_line", 19'h1, rst_line);
    repeat (40) @(negedge sys_clk);
    chk("rst_line", 19'h0, rst_line);
    chk("run", 19'h0, run);
    host.level(1'h0);
    wait_run();
    chk("rst_line", 19'h1, rst_line);
    chk("loads", 19'h2, 19'(loads));
    $display("test attention done");
  endtask

  task automatic t_dl();
    int i;
    host.pulse(0);
    wq.delete();
    host.send(11'h025, 8'h5A);
    for (i = 0; i < 40 && wq.size() < 17; i++) @(negedge sys_clk);
    chk("run", 19'h0, run);
    chk("writes", 19'h11, 19'(wq.size()));
    for (i = 0; i < 16; i++) begin
      chk("erase", {11'h020 + 11'(i), 8'hFF}, wq[i]);
    end
    chk("write", {11'h025, 8'h5A}, wq[16]);
    host.send(11'h026, 8'hA5);
    repeat (3) @(negedge sys_clk);
    chk("writes", 19'h12, 19'(wq.size()));
    chk("write", {11'h026, 8'hA5}, wq[17]);
    wq.delete();
    host.send(11'h03F, 8'hC3);
    for (i = 0; i < 40 && wq.size() < 17; i++) @(negedge sys_clk);
    chk("writes", 19'h11, 19'(wq.size()));
    chk("erase", {11'h030, 8'hFF}, wq[0]);
    chk("write", {11'h03F, 8'hC3}, wq[16]);
    host.pulse(1);
    wait_run();
    chk("run", 19'h1, run);
    chk("loads", 19'h3, 19'(loads));
    $display("test download done");
  endtask

  task automatic t_abort();
    host.pulse(0);
    host.send(11'h100, 8'h33);
    host.reset_seq();
    wait_run();
    chk("run", 19'h1, run);
    chk("rst_line", 19'h1, rst_line);
    chk("loads", 19'h4, 19'(loads));
    $display("test abort done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    srst = 1'h1;
    repeat (5) @(posedge sys_clk);
    srst <= 1'h0;
    t_power();
    t_attn();
    t_dl();
    t_abort();
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    failures++;
    print_verdict();
  end
endmodule
